// *** include/fsd_map.vh ***
/*
 Constants for the floating-point stack data-transfer block: register
 offsets, field positions, reset values, operation codes, the opcode class,
 and the built-in constants held with four bits beyond 64.
 Assumes it is included by bare name from design files only.
*/
`ifndef FSD_MAP_VH
`define FSD_MAP_VH
// ==========================================================
// Register offsets (byte addresses on the plain port)
`define FSD_REG_CTRL 4'h0
`define FSD_REG_STAT 4'h4
`define FSD_REG_FEAT 4'h8
// Control fields and reset value
`define FSD_CTRL_RC_LO 0
`define FSD_CTRL_IMASK 2
`define FSD_CTRL_RST 3'h4
// Status fields
`define FSD_STAT_TAG_LO 8
`define FSD_STAT_INV 16
// Feature bit: conditional register move present
`define FSD_FEAT_CMOV 0
// ==========================================================
// Operation select codes
`define FSD_OP_LDF 4'h0
`define FSD_OP_LDR 4'h1
`define FSD_OP_LDI 4'h2
`define FSD_OP_LDB 4'h3
`define FSD_OP_STF 4'h4
`define FSD_OP_STFP 4'h5
`define FSD_OP_STI 4'h6
`define FSD_OP_STIP 4'h7
`define FSD_OP_STBP 4'h8
`define FSD_OP_STFR 4'h9
`define FSD_OP_XCH 4'ha
`define FSD_OP_CMOV 4'hb
`define FSD_OP_CONST 4'hc
// Coprocessor opcode class: first byte 1101_1xxx
`define FSD_ESC_HI 5'h1b
// ==========================================================
// Extended format numbers
`define FSD_BIAS 15'h3fff
`define FSD_INT_E 15'h403e
`define FSD_BCD_MAX 64'h0de0b6b3a763ffff
`define FSD_BCD_INDEF 80'hffffc000000000000000
// Built-in constants: exponent and 68-bit significand
`define FSD_K_PI_E 15'h4000
`define FSD_K_PI_S 68'hc90fdaa22168c234c
`define FSD_K_L2T_E 15'h4000
`define FSD_K_L2T_S 68'hd49a784bcd1b8afe4
`define FSD_K_L2E_E 15'h3fff
`define FSD_K_L2E_S 68'hb8aa3b295c17f0bbb
`define FSD_K_LG2_E 15'h3ffd
`define FSD_K_LG2_S 68'h9a209a84fbcff7988
`define FSD_K_LN2_E 15'h3ffe
`define FSD_K_LN2_S 68'hb17217f7d1cf79abc
`define FSD_K_ONE_S 68'h80000000000000000
`endif

// *** verilog/fsd_stack_xfer.v ***
/*
 Data-transfer and constant-load engine on the eight-deep extended
 register stack: loads, stores, pops, swap, conditional move.
 Assumes the issuing decoder holds one request per cycle and reads
 store data the cycle after issue.
*/
`timescale 1ns/10ps
`include "fsd_map.vh"

module fsd_stack_xfer (
    // Clock, reset, enable
    input wire clk_i,
    input wire rstn_i,
    input wire en_i,
    // Register port
    input wire [3:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [31:0] reg_rdata_o,
    // Instruction issue
    input wire issue_i,
    input wire [7:0] opc_byte_i,
    input wire [3:0] op_i,
    input wire [2:0] rel_idx_i,
    input wire [1:0] fmt_i,
    input wire [2:0] cond_i,
    input wire [2:0] const_sel_i,
    input wire [79:0] mem_data_i,
    // Host flags register bits
    input wire carry_flag_i,
    input wire zero_flag_i,
    input wire parity_flag_i,
    // Results
    output reg done_o,
    output reg reject_o,
    output reg mem_wr_o,
    output reg [79:0] mem_data_o,
    output reg invalid_o
);

// ==========================================================
// State
reg [79:0] stk [0:7]; // Data registers, no reset: tags guard them
reg [2:0] top; // Stack index field
reg [7:0] tags; // One valid bit per physical register
reg [2:0] ctrl; // Rounding control field and invalid mask
reg inv_flag; // Sticky invalid indication

// ==========================================================
// Conversion helpers
// Increment decision for a value cut at a guard bit
function rnd_inc;
    input s, lsb, g, st;
    input [1:0] rc;
    begin
        case (rc)
            2'd0: rnd_inc = g & (st | lsb); // Nearest even
            2'd1: rnd_inc = s & (g | st); // Toward minus
            2'd2: rnd_inc = ~s & (g | st); // Toward plus
            default: rnd_inc = 1'b0; // Chop
        endcase
    end
endfunction

// Single/double to extended; denormal inputs flush to zero
function [79:0] flt2ext;
    input [63:0] v;
    input dbl;
    reg s;
    reg [10:0] ex;
    reg [51:0] f;
    begin
        s = dbl ? v[63] : v[31];
        ex = dbl ? v[62:52] : {3'h0, v[30:23]};
        f = dbl ? v[51:0] : {v[22:0], 29'h0};
        if (ex == 11'h0)
            flt2ext = {s, 79'h0};
        else if (ex == (dbl ? 11'h7ff : 11'h0ff))
            flt2ext = {s, 15'h7fff, 1'b1, f, 11'h0};
        else
            flt2ext = {s, {4'h0, ex} + (dbl ? 15'h3c00 : 15'h3f80), 1'b1, f, 11'h0};
    end
endfunction

// Two's-complement integer of width 16/32/64 to extended
function [79:0] int2ext;
    input [63:0] v;
    input [1:0] w;
    reg [63:0] x;
    reg [63:0] m;
    reg [6:0] lz;
    integer i;
    begin
        x = (w == 2'd0) ? {{48{v[15]}}, v[15:0]} :
            (w == 2'd1) ? {{32{v[31]}}, v[31:0]} : v;
        m = x[63] ? (~x + 64'h1) : x; // 100..0 stays largest negative
        lz = 7'h0;
        for (i = 0; i < 64; i = i + 1)
            if (m[63 - i] == 1'b0 && lz == i[6:0])
                lz = lz + 7'h1;
        if (m == 64'h0)
            int2ext = 80'h0;
        else
            int2ext = {x[63], `FSD_INT_E - {8'h0, lz}, m << lz};
    end
endfunction

// Eighteen-digit packed BCD to extended
function [79:0] bcd2ext;
    input [79:0] v;
    reg [63:0] b;
    reg [79:0] r;
    integer i;
    begin
        b = 64'h0;
        for (i = 17; i >= 0; i = i - 1)
            b = (b << 3) + (b << 1) + {60'h0, v[i*4 +: 4]};
        r = int2ext(b, 2'd2);
        bcd2ext = {v[79] & (b != 64'h0), r[78:0]};
    end
endfunction

// Extended to integer: {invalid, value}; w is 16, 32 or 64
function [64:0] ext2int;
    input [79:0] x;
    input [1:0] rc;
    input [6:0] w;
    reg [127:0] wd;
    reg [64:0] mag;
    reg [63:0] lim;
    reg inv;
    integer sh;
    begin
        sh = 16446 - x[78:64];
        if (x[78:64] > `FSD_INT_E)
            sh = 0;
        if (sh > 127)
            sh = 127;
        wd = {x[63:0], 64'h0} >> sh;
        mag = {1'b0, wd[127:64]} + {64'h0, rnd_inc(x[79], wd[64], wd[63], |wd[62:0], rc)};
        lim = 64'h1 << (w - 7'h1);
        inv = (x[78:64] > `FSD_INT_E) | (mag > {1'b0, lim}) | (~x[79] & (mag == {1'b0, lim}));
        ext2int = {inv, x[79] ? (~mag[63:0] + 64'h1) : mag[63:0]};
    end
endfunction

// Extended to single (low word) or double; tiny results flush to zero
function [63:0] ext2flt;
    input [79:0] x;
    input [1:0] rc;
    input dbl;
    reg [127:0] wd;
    reg [64:0] m;
    integer eb;
    begin
        wd = {x[63:0], 64'h0} >> (dbl ? 11 : 40);
        m = {1'b0, wd[127:64]} + {64'h0, rnd_inc(x[79], wd[64], wd[63], |wd[62:0], rc)};
        eb = x[78:64] - (dbl ? 15360 : 16256);
        if (m[dbl ? 53 : 24])
        begin
            m = m >> 1; // Carry out of rounding
            eb = eb + 1;
        end
        if (x[78:64] == 15'h7fff)
            eb = dbl ? 2047 : 255;
        else if (x[78:64] == 15'h0 || eb <= 0)
        begin
            eb = 0;
            m = 65'h0;
        end
        else if (eb >= (dbl ? 2047 : 255))
        begin
            eb = dbl ? 2047 : 255; // Overflow saturates to infinity
            m = 65'h0;
        end
        if (dbl)
            ext2flt = {x[79], eb[10:0], m[51:0]};
        else
            ext2flt = {32'h0, x[79], eb[7:0], m[22:0]};
    end
endfunction

// Binary magnitude to eighteen BCD digits by shift-and-add-three
function [71:0] bin2bcd;
    input [63:0] b;
    reg [71:0] d;
    integer i, j;
    begin
        d = 72'h0;
        for (i = 63; i >= 0; i = i - 1)
        begin
            for (j = 0; j < 18; j = j + 1)
                if (d[j*4 +: 4] > 4'h4)
                    d[j*4 +: 4] = d[j*4 +: 4] + 4'h3;
            d = {d[70:0], b[i]};
        end
        bin2bcd = d;
    end
endfunction

// Built-in constant, rounded from 68 to 64 significand bits
function [79:0] const_val;
    input [2:0] sel;
    input [1:0] rc;
    reg [14:0] e;
    reg [67:0] s;
    begin
        case (sel)
            3'd1: begin e = `FSD_BIAS; s = `FSD_K_ONE_S; end
            3'd2: begin e = `FSD_K_PI_E; s = `FSD_K_PI_S; end
            3'd3: begin e = `FSD_K_L2T_E; s = `FSD_K_L2T_S; end
            3'd4: begin e = `FSD_K_L2E_E; s = `FSD_K_L2E_S; end
            3'd5: begin e = `FSD_K_LG2_E; s = `FSD_K_LG2_S; end
            3'd6: begin e = `FSD_K_LN2_E; s = `FSD_K_LN2_S; end
            default: begin e = 15'h0; s = 68'h0; end // Positive zero
        endcase
        const_val = {1'b0, e, s[67:4] + {63'h0, rnd_inc(1'b0, s[4], s[3], |s[2:0], rc)}};
    end
endfunction

// ==========================================================
// Decode and operand selection
wire esc_ok = (opc_byte_i[7:3] == `FSD_ESC_HI);
wire go = en_i & issue_i & esc_ok; // no immediate field exists
wire [2:0] rel = top + rel_idx_i;
wire [2:0] push_idx = top - 3'h1;
wire [79:0] head = stk[top];
wire [79:0] relv = stk[rel];
wire [1:0] rc = ctrl[`FSD_CTRL_RC_LO +: 2];
wire [6:0] iw = (fmt_i == 2'd0) ? 7'd16 : (fmt_i == 2'd1) ? 7'd32 : 7'd64;
wire [64:0] icv = ext2int(head, rc, iw);
wire [63:0] bmag = icv[63] ? (~icv[63:0] + 64'h1) : icv[63:0];
wire binv = icv[64] | (bmag > `FSD_BCD_MAX);
reg cond_ok; // Host flag condition for the conditional move

// Condition evaluation
always @*
begin
    case (cond_i)
        3'd0: cond_ok = carry_flag_i;
        3'd1: cond_ok = ~carry_flag_i;
        3'd2: cond_ok = zero_flag_i;
        3'd3: cond_ok = ~zero_flag_i;
        3'd4: cond_ok = carry_flag_i | zero_flag_i;
        3'd5: cond_ok = ~carry_flag_i & ~zero_flag_i;
        3'd6: cond_ok = parity_flag_i;
        default: cond_ok = ~parity_flag_i;
    endcase
end

// ==========================================================
// Next-state computation for one operation
reg wa_en, wb_en, push, pop, next_wr, next_inv;
reg [2:0] wa_idx, wb_idx;
reg [79:0] wa_d, wb_d, next_data;

always @*
begin
    wa_en = 1'b0;
    wb_en = 1'b0;
    wa_idx = push_idx;
    wb_idx = top;
    wa_d = head;
    wb_d = relv;
    push = 1'b0;
    pop = 1'b0;
    next_wr = 1'b0;
    next_inv = 1'b0;
    next_data = 80'h0;
    if (go)
    begin
        case (op_i)
            `FSD_OP_LDF:
            begin
                push = 1'b1;
                wa_d = (fmt_i == 2'd2) ? mem_data_i : flt2ext(mem_data_i[63:0], fmt_i[0]);
            end
            `FSD_OP_LDR:
            begin
                push = 1'b1;
                wa_d = relv;
            end
            `FSD_OP_LDI:
            begin
                push = 1'b1;
                wa_d = int2ext(mem_data_i[63:0], fmt_i);
            end
            `FSD_OP_LDB:
            begin
                push = 1'b1;
                wa_d = bcd2ext(mem_data_i);
            end
            `FSD_OP_STF, `FSD_OP_STFP:
            begin
                next_wr = 1'b1;
                next_data = (fmt_i == 2'd2) ? head : {16'h0, ext2flt(head, rc, fmt_i[0])};
                pop = op_i[0];
            end
            `FSD_OP_STI, `FSD_OP_STIP:
            begin
                // Unmasked invalid stores nothing and leaves the stack
                next_inv = icv[64];
                next_wr = ~icv[64] | ctrl[`FSD_CTRL_IMASK];
                // Keep the bits above the integer width at zero
                next_data = icv[64] ? {16'h0, 64'h1 << (iw - 7'h1)} :
                    {16'h0, icv[63:0] & ~(64'hffffffffffffffff << iw)};
                pop = op_i[0] & next_wr;
            end
            `FSD_OP_STBP:
            begin
                next_inv = binv;
                next_wr = ~binv | ctrl[`FSD_CTRL_IMASK];
                next_data = binv ? `FSD_BCD_INDEF : {head[79], 7'h0, bin2bcd(bmag)};
                pop = next_wr;
            end
            `FSD_OP_STFR:
            begin
                wa_en = 1'b1;
                wa_idx = rel;
                pop = 1'b1;
            end
            `FSD_OP_XCH:
            begin
                wa_en = 1'b1;
                wa_idx = rel;
                wb_en = 1'b1;
            end
            `FSD_OP_CMOV:
            begin
                wb_en = cond_ok;
            end
            `FSD_OP_CONST:
            begin
                push = 1'b1;
                wa_d = const_val(const_sel_i, rc);
            end
            default:
            begin
                push = 1'b0; // Unused codes complete with no effect
            end
        endcase
        if (push)
            wa_en = 1'b1;
    end
end

// ==========================================================
// Data register writes; both ports may fire together on a swap
always @(posedge clk_i)
begin
    if (en_i)
    begin
        if (wa_en)
            stk[wa_idx] <= wa_d;
        if (wb_en)
            stk[wb_idx] <= wb_d;
    end
end

// ==========================================================
// Stack index, tags, control, status and results
always @(posedge clk_i or negedge rstn_i)
begin
    if (!rstn_i)
    begin
        top <= 3'h0;
        tags <= 8'h0;
        ctrl <= `FSD_CTRL_RST;
        inv_flag <= 1'b0;
        reg_rdata_o <= 32'h0;
        done_o <= 1'b0;
        reject_o <= 1'b0;
        mem_wr_o <= 1'b0;
        mem_data_o <= 80'h0;
        invalid_o <= 1'b0;
    end
    else if (en_i)
    begin
        done_o <= go;
        reject_o <= issue_i & ~esc_ok;
        mem_wr_o <= next_wr;
        mem_data_o <= next_data;
        invalid_o <= next_inv;
        if (push)
        begin
            top <= push_idx;
            tags[push_idx] <= 1'b1;
        end
        else if (pop)
        begin
            top <= top + 3'h1;
            tags[top] <= 1'b0;
        end
        else if (wa_en & pop)
            tags[wa_idx] <= 1'b1;
        // Store-pop to a register empties head and fills the target on the same edge, unless the target is head
        if (op_i == `FSD_OP_STFR && go && rel != top)
            tags[rel] <= 1'b1;
        if (reg_wr_i && reg_addr_i == `FSD_REG_CTRL)
            ctrl <= reg_wdata_i[2:0];
        // A new invalid wins over a clear in the same cycle
        if (next_inv)
            inv_flag <= 1'b1;
        else if (reg_wr_i && reg_addr_i == `FSD_REG_STAT && reg_wdata_i[`FSD_STAT_INV])
            inv_flag <= 1'b0;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                `FSD_REG_CTRL: reg_rdata_o <= {29'h0, ctrl};
                `FSD_REG_STAT: reg_rdata_o <= {15'h0, inv_flag, tags, 5'h0, top};
                `FSD_REG_FEAT: reg_rdata_o <= 32'h1 << `FSD_FEAT_CMOV;
                default: reg_rdata_o <= 32'h0;
            endcase
        end
        else
            reg_rdata_o <= 32'h0;
    end
end

endmodule

// *** test/fsd_host_model.sv ***
/*
 Host store sink: counts store words handed over by the block.
 Assumes store data arrive as one-cycle pulses on the write flag.
*/
`timescale 1ns/10ps
// ==========================================
// Store sink
module fsd_host_model (
    // Clock and reset
    input wire clk_i,
    input wire rstn_i,
    // Store path
    input wire mem_wr_i,
    output reg [15:0] n_store_o
);
    // One count per pulse; a stuck flag would overcount
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            n_store_o <= 16'h0;
        else if (mem_wr_i)
            n_store_o <= n_store_o + 16'h1;
    end
endmodule

// *** test/fsd_xfer_checker.sv ***
/*
 Port checker for the stack transfer engine.
 Assumes one clock domain and the bind at the foot of this file.
*/
`timescale 1ns/10ps
// ==========================================
// Checker
module fsd_xfer_checker (
    // Clock, reset, enable
    input wire clk_i,
    input wire rstn_i,
    input wire en_i,
    // Register port
    input wire [3:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [31:0] reg_rdata_o,
    // Issue and results
    input wire issue_i,
    input wire [7:0] opc_byte_i,
    input wire [3:0] op_i,
    input wire done_o,
    input wire reject_o,
    input wire mem_wr_o,
    input wire invalid_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    // Request taken this edge
    wire go = issue_i && en_i;
    // First byte within the coprocessor class
    wire coprocessor_opcode_class = opc_byte_i[7:3] == 5'h1b;
    property p_take;
        go && coprocessor_opcode_class |=> done_o && !reject_o;
    endproperty
    a_take: assert property (p_take) else $error("class opcode not completed");
    property p_refuse;
        go && !coprocessor_opcode_class |=> reject_o && !done_o && !mem_wr_o;
    endproperty
    a_refuse: assert property (p_refuse) else $error("foreign opcode not refused");
    property p_idle;
        en_i && !issue_i |=> !done_o && !reject_o && !mem_wr_o;
    endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_store;
        go && coprocessor_opcode_class && (op_i == 4'h4 || op_i == 4'h5) |=> mem_wr_o;
    endproperty
    a_store: assert property (p_store) else $error("float store wrote nothing");
    property p_load;
        go && coprocessor_opcode_class && (op_i < 4'h4 || op_i > 4'h9) |=> !mem_wr_o && !invalid_o;
    endproperty
    a_load: assert property (p_load) else $error("push wrote memory");
    property p_inv;
        invalid_o |-> $past(issue_i && op_i >= 4'h6 && op_i <= 4'h8);
    endproperty
    a_inv: assert property (p_inv) else $error("invalid without integer store");
    property p_rd;
        en_i && !reg_rd_i |=> reg_rdata_o == 32'h0;
    endproperty
    a_rd: assert property (p_rd) else $error("read data outside its cycle");
    property p_feat;
        reg_rd_i && en_i && reg_addr_i == 4'h8 |=> reg_rdata_o[0];
    endproperty
    a_feat: assert property (p_feat) else $error("move support not reported");
    property p_rc;
        reg_wr_i && en_i && reg_addr_i == 4'h0 ##1 !reg_wr_i ##1
            reg_rd_i && en_i && reg_addr_i == 4'h0
            |=> reg_rdata_o[1:0] == $past(reg_wdata_i[1:0], 3);
    endproperty
    a_rc: assert property (p_rc) else $error("rounding field lost");
endmodule

bind fsd_stack_xfer fsd_xfer_checker u_chk (.clk_i, .rstn_i, .en_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .issue_i, .opc_byte_i, .op_i,
    .done_o, .reject_o, .mem_wr_o, .invalid_o);

// *** test/fsd_stack_xfer_tb_top.sv ***
/*
 Bench for the stack transfer engine: registers, refusals, loads,
 stores, pops, swap, conditional moves, constants.
 Assumes the host model and the bound checker are compiled first.
*/
`timescale 1ns/10ps
// ==========================================
// Bench top
module fsd_stack_xfer_tb_top;
    // Stimulus
    logic clk_i, rstn_i, en_i, reg_wr_i, reg_rd_i, issue_i;
    logic carry_flag_i, zero_flag_i, parity_flag_i;
    logic [3:0] reg_addr_i, op_i;
    logic [31:0] reg_wdata_i;
    logic [7:0] opc_byte_i;
    logic [2:0] rel_idx_i, cond_i, const_sel_i;
    logic [1:0] fmt_i;
    logic [79:0] mem_data_i;
    // Results
    wire [31:0] reg_rdata_o;
    wire done_o, reject_o, mem_wr_o, invalid_o;
    wire [79:0] mem_data_o;
    wire [15:0] n_store;
    // Bookkeeping
    integer n_fail = 0;
    integer total_checks = 0;
    integer i;
    logic [15:0] exp_st = 16'h0;
    logic [7:0] cur_opc = 8'hd9;
    logic [79:0] kt [8];
    localparam logic [79:0] one_x = 80'h3fff8000000000000000;
    localparam logic [79:0] neg_x = 80'hc00e8000000000000000;
    localparam logic [31:0] opcs = 32'hd7d8dfe0;

    fsd_stack_xfer uut (.clk_i, .rstn_i, .en_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .issue_i, .opc_byte_i, .op_i, .rel_idx_i, .fmt_i,
        .cond_i, .const_sel_i, .mem_data_i, .carry_flag_i, .zero_flag_i,
        .parity_flag_i, .done_o, .reject_o, .mem_wr_o, .mem_data_o, .invalid_o);
    fsd_host_model u_host (.clk_i, .rstn_i, .mem_wr_i(mem_wr_o), .n_store_o(n_store));

    // ==========================================
    // Clock and watchdog
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    // Full run needs about 800 cycles
    initial
    begin
        #125000;
        n_fail = n_fail + 1;
        finish_test;
    end

    // ==========================================
    // Tasks
    task chk(input [79:0] got, input [79:0] e);
        begin
            total_checks = total_checks + 1;
            if (got !== e)
            begin
                n_fail = n_fail + 1;
                $display("mismatch %0t got %h want %h", $time, got, e);
            end
        end
    endtask
    // Read: data stand one cycle after the strobe
    task rd(input [3:0] a, input [31:0] e);
        begin
            @(posedge clk_i);
            reg_rd_i <= 1'b1;
            reg_addr_i <= a;
            @(posedge clk_i);
            reg_rd_i <= 1'b0;
            #1;
            chk({48'h0, reg_rdata_o}, {48'h0, e});
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        begin
            @(posedge clk_i);
            reg_wr_i <= 1'b1;
            reg_addr_i <= a;
            reg_wdata_i <= d;
            @(posedge clk_i);
            reg_wr_i <= 1'b0;
        end
    endtask
    // Issue one request; k feeds format, condition and constant select
    task op(input [3:0] o, input [2:0] r, input [2:0] k, input [79:0] d);
        begin
            @(posedge clk_i);
            issue_i <= 1'b1;
            opc_byte_i <= cur_opc;
            op_i <= o;
            rel_idx_i <= r;
            fmt_i <= k[1:0];
            cond_i <= k;
            const_sel_i <= k;
            mem_data_i <= d;
            @(posedge clk_i);
            issue_i <= 1'b0;
            // Operand line released: never leave the old value showing
            mem_data_i <= ~d;
            #1;
        end
    endtask
    task st(input [3:0] o, input [2:0] k, input [79:0] e);
        begin
            op(o, 3'h0, k, 80'h0);
            chk(mem_data_o, e);
            chk({79'h0, mem_wr_o}, 80'h1);
            exp_st = exp_st + 16'h1;
        end
    endtask
    task sp(input [79:0] e);
        begin
            st(4'h5, 3'h2, e);
        end
    endtask
    // Condition table, flags packed as parity, zero, carry
    function automatic logic take(input [2:0] c, input [2:0] f);
        logic [7:0] t;
        begin
            t = {~f[2], f[2], ~(f[0] | f[1]), f[0] | f[1], ~f[1], f[1], ~f[0], f[0]};
            take = t[c];
        end
    endfunction
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    // ==========================================
    // Main sequence
    initial
    begin
        kt[0] = 80'h0;
        kt[1] = one_x;
        kt[2] = 80'h4000c90fdaa22168c234;
        kt[3] = 80'h4000d49a784bcd1b8afe;
        kt[4] = 80'h3fffb8aa3b295c17f0bb;
        kt[5] = 80'h3ffd9a209a84fbcff798;
        kt[6] = 80'h3ffeb17217f7d1cf79ab;
        kt[7] = 80'h0;
        {rstn_i, reg_wr_i, reg_rd_i, issue_i} = 4'h0;
        {en_i, carry_flag_i, zero_flag_i, parity_flag_i} = 4'h8;
        {reg_addr_i, op_i, reg_wdata_i, opc_byte_i} = 48'h0;
        {rel_idx_i, cond_i, const_sel_i, fmt_i} = 11'h0;
        mem_data_i = 80'h0;
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(4'h0, 32'h4);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h1);
        rd(4'hc, 32'h0);
        // Refused bytes leave the stack alone
        for (i = 0; i < 4; i++)
        begin
            cur_opc = opcs[31 - 8 * i -: 8];
            op(4'hc, 3'h0, 3'h0, 80'h0);
            chk({78'h0, reject_o, done_o}, (i % 3 == 0) ? 80'h2 : 80'h1);
        end
        cur_opc = 8'hd9;
        rd(4'h4, 32'hc006);
        sp(80'h0);
        sp(80'h0);
        rd(4'h4, 32'h0);
        // Let the last answer drop before freezing, so no pulse is held
        @(posedge clk_i);
        en_i <= 1'b0;
        op(4'hc, 3'h0, 3'h1, 80'h0);
        chk({79'h0, done_o}, 80'h0);
        en_i <= 1'b1;
        // Loads from single, double, 16- and 32-bit integer and BCD sources
        op(4'h0, 3'h0, 3'h0, 80'h3f800000);
        st(4'h4, 3'h2, one_x);
        op(4'h0, 3'h0, 3'h1, 80'h3ff0000000000000);
        st(4'h4, 3'h2, one_x);
        op(4'h2, 3'h0, 3'h1, 80'h1);
        st(4'h4, 3'h2, one_x);
        op(4'h3, 3'h0, 3'h0, 80'h1);
        st(4'h4, 3'h2, one_x);
        op(4'h2, 3'h0, 3'h0, 80'h8000);
        st(4'h4, 3'h2, neg_x);
        st(4'h4, 3'h1, 80'hc0e0000000000000);
        st(4'h4, 3'h0, 80'hc7000000);
        st(4'h6, 3'h0, 80'h8000);
        // Register moves, relative to the head
        op(4'h1, 3'h1, 3'h2, 80'h0);
        st(4'h4, 3'h2, one_x);
        op(4'ha, 3'h1, 3'h0, 80'h0);
        st(4'h4, 3'h2, neg_x);
        op(4'h9, 3'h1, 3'h0, 80'h0);
        chk({79'h0, mem_wr_o}, 80'h0);
        st(4'h4, 3'h2, neg_x);
        // Masked overflow gives the indefinite, then pops
        op(4'h0, 3'h0, 3'h2, 80'h7ffe8000000000000000);
        st(4'h7, 3'h0, 80'h8000);
        st(4'h4, 3'h2, neg_x);
        // Every condition against every flag pattern
        for (i = 0; i < 64; i++)
        begin
            {parity_flag_i, zero_flag_i, carry_flag_i} <= i[2:0];
            op(4'hc, 3'h0, 3'h0, 80'h0);
            op(4'hc, 3'h0, 3'h1, 80'h0);
            op(4'hb, 3'h1, i[5:3], 80'h0);
            sp(take(i[5:3], i[2:0]) ? 80'h0 : one_x);
            sp(80'h0);
        end
        // All constants truncated, then pi under each rounding mode
        wr(4'h0, 32'h7);
        for (i = 0; i < 8; i++)
        begin
            op(4'hc, 3'h0, i[2:0], 80'h0);
            sp(kt[i]);
        end
        for (i = 0; i < 4; i++)
        begin
            wr(4'h0, 32'h4 | i);
            rd(4'h0, 32'h4 | i);
            op(4'hc, 3'h0, 3'h2, 80'h0);
            sp(kt[2] + {79'h0, ~i[0]});
        end
        @(posedge clk_i);
        #1;
        chk({64'h0, n_store}, {64'h0, exp_st});
        finish_test;
    end
endmodule
